//--- hdl/dram_init_ctrl.sv
// Contract
// - hold reset low for at least the programmed reset pulse width.
// - drive CKE low at least 10 ns before releasing reset.
// - after release, repeat power-on steps then load mode registers.
// - wait 500 us after reset release before raising CKE.
// - wait tXPR after CKE high before the first mode register write.
// - load MR3,MR6,MR5,MR4,MR2,MR1,MR0; tMRD between, tMOD after last.
// - only DES in slots between first mode write and ZQ long.
// - write every mode register during the init sequence.
// - DLL enable in MR1 is written before DLL reset in MR0.
// - hold boundary scan enable low throughout reset and init.
// - mode registers undefined after reset; write all before use.
// - each mode write carries a full value for the register.
// - runtime mode write only when idle, banks precharged, CKE high.
// - with nominal termination on, ODT low before a mode write.
// - ODT may rise again only after tMOD from the mode write.
// - with nominal termination off, ODT may be either level.
// - space consecutive mode writes by at least tMRD.
// - after a mode write wait tMOD before non-mode, non-DES command.
module dram_init_ctrl
   import dram_init_pkg::*;
#(
   parameter int RST_WAIT = RST_WAIT_CYC
)(
   // clock and reset
   input  wire logic                 ref_clk,
   input  wire logic                 rst,
   // user control
   input  wire logic                 warm_reset_req,
   input  wire logic [CNT_W-1:0]     cfg_pw_reset,
   input  wire logic [CNT_W-1:0]     cfg_xpr,
   input  wire logic [CNT_W-1:0]     cfg_mrd,
   input  wire logic [CNT_W-1:0]     cfg_mod,
   input  wire logic                 rtt_nom_en,
   input  wire logic [NUM_MR*MR_DATA_W-1:0] mr_init_val,
   // runtime mode write request
   input  wire logic                 rt_mrs_valid,
   input  wire logic [MR_SEL_W-1:0]  rt_mrs_sel,
   input  wire logic [MR_DATA_W-1:0] rt_mrs_data,
   input  wire logic                 dev_idle,
   output logic                      rt_mrs_ready,
   // user command request
   input  wire logic                 user_cmd_valid,
   output logic                      user_cmd_ready,
   input  wire logic                 user_odt,
   // status
   output logic                      init_done,
   // dram pins
   output logic                      dram_reset_n,
   output logic                      dram_cke,
   output logic                      dram_ck_en,
   output logic                      dram_odt,
   output logic                      dram_ten,
   output dram_cmd_e                 dram_cmd,
   output logic [MR_SEL_W-1:0]       dram_mr_sel,
   output logic [MR_DATA_W-1:0]      dram_mr_data
);
   // ---------------------------------------------------------------
   // helpers
   // ---------------------------------------------------------------
   // pick the mode register number for a load step
   function automatic logic [MR_SEL_W-1:0] order_sel(input logic [2:0] i);
      order_sel = MR_ORDER[i*3 +: 3];
   endfunction

   // pick the stored value for a mode register
   function automatic logic [MR_DATA_W-1:0] mr_val(
      input logic [MR_SEL_W-1:0] s, input logic [NUM_MR*MR_DATA_W-1:0] v);
      mr_val = v[s*MR_DATA_W +: MR_DATA_W];
   endfunction

   spacing_if sp ();
   spacing_timer u_spacing_timer (
      .ref_clk (ref_clk),
      .rst     (rst),
      .sp      (sp)
   );

   init_state_e      state_ff;
   init_state_e      nxt_state;
   logic [2:0]       step_ff;
   logic [CNT_W-1:0] wait_ff;
   logic [CNT_W-1:0] mod_cnt_ff;
   logic             rtt_ff;
   logic             rt_go;
   logic             tick;

   assign tick  = sp.done;
   assign rt_go = (state_ff == ST_READY) && rt_mrs_valid && dev_idle
                  && dram_cke && tick;

   // ---------------------------------------------------------------
   // sequencing
   // ---------------------------------------------------------------
   always_comb begin
      nxt_state = state_ff;
      unique case (state_ff)
         ST_RESET:   if (tick) nxt_state = ST_CKE_LO;
         ST_CKE_LO:  if (tick) nxt_state = ST_RST_REL;
         ST_RST_REL: if (tick) nxt_state = ST_CLK_STB;
         ST_CLK_STB: if (tick) nxt_state = ST_XPR;
         ST_XPR:     if (tick) nxt_state = ST_MRS;
         ST_MRS:     if (tick && step_ff == 3'h6)
                        nxt_state = ST_ZQCL;
         ST_ZQCL:    if (tick) nxt_state = ST_READY;
         ST_READY:   nxt_state = ST_READY;
      endcase
      if (warm_reset_req) nxt_state = ST_RESET;
   end

   always_ff @(posedge ref_clk) begin
      if (rst) state_ff <= ST_RESET;
      else     state_ff <= nxt_state;
   end

   // step through the load order, MR1 before MR0 for the DLL
   always_ff @(posedge ref_clk) begin
      if (rst || state_ff != ST_MRS) step_ff <= 3'h0;
      else if (tick) step_ff <= step_ff + 3'h1;
   end

   // ---------------------------------------------------------------
   // spacing requests
   // ---------------------------------------------------------------
   always_comb begin
      sp.load  = 1'b0;
      sp.value = '0;
      if (warm_reset_req || rst) begin
         sp.load  = 1'b1;
         sp.value = cfg_pw_reset;
      end else if (state_ff != nxt_state) begin
         sp.load = 1'b1;
         unique case (nxt_state)
            ST_CKE_LO:  sp.value = CNT_W'(CKE_LEAD_CYC);
            ST_RST_REL: sp.value = CNT_W'(RST_WAIT);
            ST_CLK_STB: sp.value = CNT_W'(CLK_STABLE_CYC);
            ST_XPR:     sp.value = cfg_xpr;
            ST_MRS:     sp.value = '0;
            ST_ZQCL:    sp.value = cfg_mod;
            default:    sp.value = '0;
         endcase
      end else if (state_ff == ST_MRS && tick) begin
         sp.load  = 1'b1;
         sp.value = (step_ff == 3'h6) ? cfg_mod : cfg_mrd;
      end else if (rt_go) begin
         sp.load  = 1'b1;
         sp.value = cfg_mrd;
      end
   end

   // cycles of cfg_mod left after the last runtime mode write, holding at zero
   always_ff @(posedge ref_clk) begin
      if (rst) mod_cnt_ff <= '0;
      else if (rt_go) mod_cnt_ff <= cfg_mod;
      else if (mod_cnt_ff != '0) mod_cnt_ff <= mod_cnt_ff - 20'h00001;
   end

   // remember whether nominal termination was on around the write
   always_ff @(posedge ref_clk) begin
      if (rst) rtt_ff <= 1'b0;
      else if (rt_go) rtt_ff <= rtt_nom_en;
      else if (mod_cnt_ff == '0) rtt_ff <= rtt_nom_en;
   end

   assign rt_mrs_ready   = rt_go;
   assign user_cmd_ready = (state_ff == ST_READY) && (mod_cnt_ff == '0)
                           && !rt_mrs_valid;
   assign init_done      = (state_ff == ST_READY);

   // ---------------------------------------------------------------
   // pin drivers
   // ---------------------------------------------------------------
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         dram_reset_n <= 1'b0;
         dram_cke     <= 1'b0;
         dram_ck_en   <= 1'b0;
         dram_ten     <= 1'b0;
      end else begin
         dram_reset_n <= !(nxt_state == ST_RESET || nxt_state == ST_CKE_LO);
         dram_cke     <= (nxt_state == ST_XPR || nxt_state == ST_MRS ||
                          nxt_state == ST_ZQCL || nxt_state == ST_READY);
         dram_ck_en   <= !(nxt_state == ST_RESET ||
                           nxt_state == ST_CKE_LO ||
                           nxt_state == ST_RST_REL);
         dram_ten     <= 1'b0;
      end
   end

   // command, mode register address and data
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         dram_cmd     <= CMD_DES;
         dram_mr_sel  <= '0;
         dram_mr_data <= '0;
      end else if (state_ff == ST_MRS && tick && !warm_reset_req) begin
         dram_cmd     <= CMD_MRS;
         dram_mr_sel  <= order_sel(step_ff);
         dram_mr_data <= mr_val(order_sel(step_ff), mr_init_val);
      end else if (state_ff == ST_ZQCL && tick && !warm_reset_req) begin
         dram_cmd     <= CMD_ZQCL;
      end else if (rt_go && !warm_reset_req) begin
         dram_cmd     <= CMD_MRS;
         dram_mr_sel  <= rt_mrs_sel;
         dram_mr_data <= rt_mrs_data;
      end else if (user_cmd_valid && user_cmd_ready && !warm_reset_req)
      begin
         dram_cmd     <= CMD_USER;
      end else begin
         dram_cmd     <= CMD_DES;
      end
   end

   // odt static low during init; low around mode writes with rtt on
   always_ff @(posedge ref_clk) begin
      if (rst) dram_odt <= 1'b0;
      else if (state_ff != ST_READY) dram_odt <= 1'b0;
      else if ((rtt_ff || rtt_nom_en) &&
               (rt_mrs_valid || mod_cnt_ff != '0))
         dram_odt <= 1'b0;
      else dram_odt <= user_odt;
   end

   // ---------------------------------------------------------------
   // checks
   // ---------------------------------------------------------------
   property p_ten_low;
      @(posedge ref_clk) disable iff (rst) !dram_ten;
   endproperty
   a_ten_low: assert property (p_ten_low)
      else $error("boundary scan enable driven high");

   property p_cke_before_rel;
      @(posedge ref_clk) disable iff (rst)
      $rose(dram_reset_n) |-> !dram_cke && $past(!dram_cke);
   endproperty
   a_cke_before_rel: assert property (p_cke_before_rel)
      else $error("reset released without cke low lead");

   property p_no_cke_in_reset;
      @(posedge ref_clk) disable iff (rst) !dram_reset_n |-> !dram_cke;
   endproperty
   a_no_cke_in_reset: assert property (p_no_cke_in_reset)
      else $error("cke high while reset asserted");

   property p_mrs_spacing;
      @(posedge ref_clk) disable iff (rst || warm_reset_req)
      (dram_cmd == CMD_MRS && cfg_mrd > 20'h00001) |=>
         dram_cmd != CMD_MRS;
   endproperty
   a_mrs_spacing: assert property (p_mrs_spacing)
      else $error("mode writes back to back");

   property p_user_after_mod;
      @(posedge ref_clk) disable iff (rst)
      dram_cmd == CMD_USER |-> $past(mod_cnt_ff) == '0;
   endproperty
   a_user_after_mod: assert property (p_user_after_mod)
      else $error("user command inside mode write delay");

   property p_odt_init;
      @(posedge ref_clk) disable iff (rst) !init_done |=> !dram_odt;
   endproperty
   a_odt_init: assert property (p_odt_init)
      else $error("odt high during initialisation");

   property p_rt_idle;
      @(posedge ref_clk) disable iff (rst)
      rt_mrs_ready |-> dev_idle && dram_cke;
   endproperty
   a_rt_idle: assert property (p_rt_idle)
      else $error("runtime mode write while not idle");

   property p_odt_mod;
      @(posedge ref_clk) disable iff (rst)
      (rt_go && rtt_nom_en) |=> !dram_odt [*2];
   endproperty
   a_odt_mod: assert property (p_odt_mod)
      else $error("odt raised inside mode write delay");
endmodule

//--- hdl/dram_init_pkg.sv
package dram_init_pkg;
   // ----------------------------------------------------------------
   // clock and timing
   // ----------------------------------------------------------------
   localparam int CLK_PERIOD_PS    = 10000;
   localparam int CKE_LEAD_NS      = 10;
   localparam int CKE_LEAD_CYC     =
      (CKE_LEAD_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int RST_WAIT_US      = 500;
   localparam int RST_WAIT_CYC     =
      (RST_WAIT_US * 1000000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int CLK_STABLE_NS    = 10;
   localparam int CLK_STABLE_TCK   = 5;
   localparam int CLK_STABLE_CYC   =
      ((CLK_STABLE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS >
       CLK_STABLE_TCK) ?
      (CLK_STABLE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS :
      CLK_STABLE_TCK;
   localparam int CNT_W            = 20;
   // default timing counts, reloadable at run time
   localparam logic [CNT_W-1:0] DEF_PW_RESET = 20'h00064;
   localparam logic [CNT_W-1:0] DEF_XPR      = 20'h00030;
   localparam logic [CNT_W-1:0] DEF_MRD      = 20'h00008;
   localparam logic [CNT_W-1:0] DEF_MOD      = 20'h00018;
   // ----------------------------------------------------------------
   // mode register set
   // ----------------------------------------------------------------
   localparam int NUM_MR           = 7;
   localparam int MR_DATA_W        = 18;
   localparam int MR_SEL_W         = 3;
   // load order during initialisation: 3,6,5,4,2,1,0
   localparam logic [20:0] MR_ORDER = {3'h0, 3'h1, 3'h2, 3'h4,
                                       3'h5, 3'h6, 3'h3};
   // command encodings on the controller's command output
   typedef enum logic [2:0] {
      CMD_DES  = 3'h0,
      CMD_MRS  = 3'h1,
      CMD_ZQCL = 3'h2,
      CMD_USER = 3'h3
   } dram_cmd_e;
   // state machine
   typedef enum logic [7:0] {
      ST_RESET   = 8'h01,
      ST_CKE_LO  = 8'h02,
      ST_RST_REL = 8'h04,
      ST_CLK_STB = 8'h08,
      ST_XPR     = 8'h10,
      ST_MRS     = 8'h20,
      ST_ZQCL    = 8'h40,
      ST_READY   = 8'h80
   } init_state_e;
endpackage

//--- hdl/spacing_if.sv
// carries a spacing request from the sequencer to the timing counter
interface spacing_if
   import dram_init_pkg::*;
   ();
   logic             load;
   logic [CNT_W-1:0] value;
   logic             done;
   modport owner (output load, output value, input done);
   modport timer (input load, input value, output done);
endinterface

//--- hdl/spacing_timer.sv
// ------------------------------------------------------------------
// down counter loaded with a cycle count; done when it has expired
// ------------------------------------------------------------------
module spacing_timer
   import dram_init_pkg::*;
(
   // clock and reset
   input  wire logic ref_clk,
   input  wire logic rst,
   // request
   spacing_if.timer  sp
);
   logic [CNT_W-1:0] count_ff;

   // load counts down to zero, one per clock; the sequencer loads the
   // reset pulse width while rst is high, so a load wins over rst
   always_ff @(posedge ref_clk) begin
      if (sp.load) begin
         count_ff <= (sp.value == '0) ? '0 : sp.value - 20'h00001;
      end else if (rst) begin
         count_ff <= '0;
      end else if (count_ff != '0) begin
         count_ff <= count_ff - 20'h00001;
      end
   end

   // done from the register only: the load decision reads it back
   assign sp.done = (count_ff == '0);
endmodule

//--- sim/dram_dev_model.sv
// ------------------------------------------------------------------
// behavioural memory device: mode register file and a fixed array
// ------------------------------------------------------------------
module dram_dev_model
   import dram_init_pkg::*;
(
   // clock
   input  wire logic                          ref_clk,
   // controller pins
   input  wire logic                          reset_n,
   input  wire logic                          cke,
   input  wire logic                          ck_en,
   input  wire logic                          ten,
   input  wire dram_cmd_e                     cmd,
   input  wire logic [MR_SEL_W-1:0]           mr_sel,
   input  wire logic [MR_DATA_W-1:0]          mr_data,
   // observation
   output logic [NUM_MR*MR_DATA_W-1:0]        mr_all,
   output logic [NUM_MR-1:0]                  mr_valid,
   output logic [31:0]                        arr_word
);
   timeunit 1ns;
   timeprecision 1ps;
   // array content is set once; mode writes never reach it
   initial arr_word = 32'hA5C30F96;

   // reset scrambles contents; a mode write replaces a whole register
   always_ff @(posedge ref_clk) begin
      if (!reset_n) begin
         mr_all   <= ~mr_all;
         mr_valid <= '0;
      end else if (ck_en && cke && !ten && cmd == CMD_MRS &&
                   mr_sel < 3'h7) begin
         mr_all[mr_sel*MR_DATA_W +: MR_DATA_W] <= mr_data;
         mr_valid[mr_sel]                      <= 1'b1;
      end
   end
endmodule

//--- sim/dram_init_ctrl_test.sv
module dram_init_ctrl_test
   import dram_init_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int RWAIT   = 20;
   localparam int ORD [7] = '{3, 6, 5, 4, 2, 1, 0};
   logic                   ref_clk, rst, warm_reset_req, rtt_nom_en;
   logic [CNT_W-1:0]       cfg_pw_reset, cfg_xpr, cfg_mrd, cfg_mod;
   logic [125:0]           mr_init_val, exp_mr, mr_all;
   logic                   rt_mrs_valid, dev_idle, rt_mrs_ready;
   logic [2:0]             rt_mrs_sel, dram_mr_sel;
   logic [17:0]            rt_mrs_data, dram_mr_data;
   logic                   user_cmd_valid, user_cmd_ready, user_odt;
   logic                   init_done, dram_reset_n, dram_cke, dram_ck_en;
   logic                   dram_odt, dram_ten, prev_rn, prev_cke, prev_ck;
   dram_cmd_e              dram_cmd;
   logic [6:0]             mr_valid;
   logic [31:0]            arr_word;
   logic                   v;
   int                     fails, compares, cyc, t_fall, t_rise, t_ck;
   int                     t_cke, t_mrs, idx, in_init;

   dram_init_ctrl #(.RST_WAIT(RWAIT)) u_dram_init_ctrl (
      .ref_clk(ref_clk), .rst(rst), .warm_reset_req(warm_reset_req),
      .cfg_pw_reset(cfg_pw_reset), .cfg_xpr(cfg_xpr), .cfg_mrd(cfg_mrd),
      .cfg_mod(cfg_mod), .rtt_nom_en(rtt_nom_en), .mr_init_val(mr_init_val),
      .rt_mrs_valid(rt_mrs_valid), .rt_mrs_sel(rt_mrs_sel),
      .rt_mrs_data(rt_mrs_data), .dev_idle(dev_idle),
      .rt_mrs_ready(rt_mrs_ready), .user_cmd_valid(user_cmd_valid),
      .user_cmd_ready(user_cmd_ready), .user_odt(user_odt),
      .init_done(init_done), .dram_reset_n(dram_reset_n),
      .dram_cke(dram_cke), .dram_ck_en(dram_ck_en), .dram_odt(dram_odt),
      .dram_ten(dram_ten), .dram_cmd(dram_cmd), .dram_mr_sel(dram_mr_sel),
      .dram_mr_data(dram_mr_data));
   dram_dev_model u_dram_dev_model (.ref_clk(ref_clk),
      .reset_n(dram_reset_n), .cke(dram_cke), .ck_en(dram_ck_en),
      .ten(dram_ten), .cmd(dram_cmd), .mr_sel(dram_mr_sel),
      .mr_data(dram_mr_data), .mr_all(mr_all), .mr_valid(mr_valid),
      .arr_word(arr_word));

   // clock generation
   initial begin
      ref_clk = 0;
      forever #5 ref_clk = ~ref_clk;
   end
   // ----------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------
   function automatic int eff(input logic [CNT_W-1:0] c);
      return (c < 2) ? 1 : int'(c);
   endfunction
   task automatic chk(input string nm, input logic [31:0] e,
                      input logic [31:0] g);
      compares++;
      if (g !== e) begin
         fails++;
         $display("BAD %s expected %0h seen %0h", nm, e, g);
      end
   endtask
   task automatic wrap_up;
      $display("compares %0d fails %0d", compares, fails);
      if (fails == 0 && compares > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   task automatic tick;
      @(posedge ref_clk);
      #1;
   endtask
   task automatic wait_done;
      int n;
      n = 0;
      while (init_done !== 1'b1) begin
         tick();
         n++;
         if (n > 2000) begin
            chk("init_timeout", 1, 0);
            wrap_up();
         end
      end
   endtask
   task automatic mr_cmp(input string nm);
      for (int i = 0; i < 7; i++)
         chk(nm, 32'(exp_mr[i*18 +: 18]), 32'(mr_all[i*18 +: 18]));
   endtask
   // hold the request until taken; user commands must stay refused
   task automatic rt_write(input logic [2:0] s, input logic [17:0] d);
      int n;
      rt_mrs_sel   = s;
      rt_mrs_data  = d;
      rt_mrs_valid = 1;
      n = 0;
      do begin
         @(negedge ref_clk);
         chk("user_refused", 0, 32'(user_cmd_ready));
         n++;
         if (n > 500) begin
            chk("rt_timeout", 1, 0);
            wrap_up();
         end
      end while (rt_mrs_ready !== 1'b1);
      exp_mr[s*18 +: 18] = d;
      tick();
   endtask
   // ----------------------------------------------------------------
   // pin monitor: timing of the reset and mode write sequence
   // ----------------------------------------------------------------
   always @(negedge ref_clk) begin
      cyc = cyc + 1;
      if (rst) begin
         t_fall  = cyc;
         in_init = 1;
      end else begin
         chk("ten_low", 0, 32'(dram_ten));
         if (in_init)
            chk("init_odt", 0, 32'(dram_odt));
         if (!dram_reset_n && prev_rn) begin
            t_fall  = cyc;
            in_init = 1;
         end
         if (dram_reset_n && !prev_rn) begin
            chk("pw_reset", 1, 32'(cyc - t_fall > eff(cfg_pw_reset)));
            chk("cke_lead", 0, 32'(prev_cke));
            t_rise = cyc;
            idx    = 0;
         end
         if (dram_ck_en && !prev_ck)
            t_ck = cyc;
         if (dram_cke && !prev_cke) begin
            chk("rst_wait", 1, 32'(cyc - t_rise >= RWAIT));
            chk("clk_stable", 1, 32'(cyc - t_ck >= 5));
            t_cke = cyc;
         end
         if (dram_cmd == CMD_MRS) begin
            if (in_init && idx == 0)
               chk("xpr", 1, 32'(cyc - t_cke >= eff(cfg_xpr)));
            if (in_init) begin
               chk("mr_order", ORD[idx % 7], 32'(dram_mr_sel));
               idx = idx + 1;
            end
            if (!in_init || idx > 1)
               chk("mrd", 1, 32'(cyc - t_mrs >= eff(cfg_mrd)));
            t_mrs = cyc;
         end
         if (dram_cmd == CMD_ZQCL) begin
            chk("mr_count", 7, 32'(idx));
            chk("zq_mod", 1, 32'(cyc - t_mrs >= eff(cfg_mod)));
            in_init = 0;
         end
         if (dram_cmd == CMD_USER)
            chk("user_mod", 1,
                32'(!in_init && cyc - t_mrs >= eff(cfg_mod)));
         if (dram_odt && rtt_nom_en)
            chk("odt_mod", 1, 32'(cyc - t_mrs >= eff(cfg_mod)));
      end
      prev_rn  = dram_reset_n;
      prev_cke = dram_cke;
      prev_ck  = dram_ck_en;
   end
   // ----------------------------------------------------------------
   // main sequence
   // ----------------------------------------------------------------
   initial begin
      void'($urandom(26));
      {fails, compares, cyc, t_rise, t_ck, t_cke, idx} = '0;
      t_mrs          = -1000;
      {prev_rn, prev_cke, prev_ck} = 3'h1;
      rst            = 1;
      warm_reset_req = 0;
      rtt_nom_en     = 1;
      cfg_pw_reset   = 20'(2 + $urandom % 5);
      cfg_xpr        = 20'(2 + $urandom % 5);
      cfg_mrd        = 20'(2 + $urandom % 5);
      cfg_mod        = 20'(cfg_mrd + $urandom % 4);
      mr_init_val    = 126'({$urandom, $urandom, $urandom, $urandom});
      {rt_mrs_valid, rt_mrs_sel, rt_mrs_data} = '0;
      {dev_idle, user_cmd_valid, user_odt} = 3'h0;
      repeat (4) tick();
      rst = 0;
      wait_done();
      exp_mr = mr_init_val;
      mr_cmp("mr_init");
      chk("mr_all_set", 32'h7F, 32'(mr_valid));
      // runtime writes: refused while busy, then back to back
      user_cmd_valid = 1;
      user_odt       = 1;
      rt_mrs_valid   = 1;
      repeat (8) begin
         @(negedge ref_clk);
         chk("busy_refuse", 0, 32'(rt_mrs_ready));
      end
      tick();
      dev_idle = 1;
      for (int i = 0; i < 8; i++)
         rt_write(i < 2 ? 3'(1 - i) : 3'($urandom % 7),
                  18'($urandom));
      rt_mrs_valid = 0;
      repeat (40) tick();
      mr_cmp("mr_rt");
      chk("array", 32'hA5C30F96, arr_word);
      // termination off: odt follows the user request
      rtt_nom_en = 0;
      repeat (8) begin
         v        = 1'($urandom);
         user_odt = v;
         @(negedge ref_clk);
         @(negedge ref_clk);
         chk("odt_follow", 32'(v), 32'(dram_odt));
         chk("user_ready", 1, 32'(user_cmd_ready));
         chk("user_cmd", 32'(CMD_USER), 32'(dram_cmd));
         tick();
      end
      // warm reset, then again in the middle of the mode writes
      rtt_nom_en     = 1;
      user_cmd_valid = 0;
      user_odt       = 0;
      warm_reset_req = 1;
      tick();
      warm_reset_req = 0;
      repeat (RWAIT + 40) tick();
      warm_reset_req = 1;
      tick();
      warm_reset_req = 0;
      repeat (3) tick();
      chk("mr_cleared", 0, 32'(mr_valid));
      wait_done();
      exp_mr = mr_init_val;
      mr_cmp("mr_rewarm");
      chk("mr_all_set2", 32'h7F, 32'(mr_valid));
      wrap_up();
   end
endmodule
